// ==== verilog/pmu_pkg.sv ====
// package for the power manager: states, timer defaults and carrier structs
package pmu_pkg;

  // ------------------------------------------------------------
  // power states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PMU_ON      = 2'b00,
    PMU_DOZE    = 2'b01,
    PMU_STANDBY = 2'b10,
    PMU_SUSPEND = 2'b11
  } pmu_state_t;

  // ------------------------------------------------------------
  // suspend handshake
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PMU_SH_RUN   = 2'b00,
    PMU_SH_DRAIN = 2'b01,
    PMU_SH_HALT  = 2'b10,
    PMU_SH_WAKE  = 2'b11
  } pmu_sh_t;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int          PMU_TW          = 16;
  localparam int          PMU_PLANES      = 4;
  localparam logic [15:0] PMU_DOZE_RST    = 16'h0100;
  localparam logic [15:0] PMU_STBY_RST    = 16'h1000;
  localparam logic [15:0] PMU_SUSPEND_THROTTLE_OUT_RST    = 16'hF000;
  localparam logic [15:0] PMU_HK_RST      = 16'h0040;
  localparam logic [15:0] PMU_PERIPH_RST  = 16'h2000;
  localparam logic [3:0]  PMU_THR_RST     = 4'hF;
  localparam logic [3:0]  PMU_PLANES_RST  = 4'hF;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] doze;
    logic [15:0] standby;
    logic [15:0] suspend;
    logic [15:0] housekeep;
    logic [15:0] periph;
  } pmu_reload_t;

  typedef struct packed {
    logic system;
    logic housekeep;
    logic periph;
  } pmu_activity_t;

  typedef struct packed {
    logic doze;
    logic standby;
    logic suspend;
    logic periph;
    logic wake;
  } pmu_cause_t;

endpackage : pmu_pkg

// ==== verilog/pmu_power_manager.sv ====
// power manager: inactivity timers, power states, throttle and suspend control
`timescale 1ns/1ns

// Notes on behaviour
// - three idle timers: doze short, standby medium, suspend long
// - idle timer expiry can raise a management interrupt
// - activity while powered down can raise a management interrupt
// - states on, doze, standby, suspend with falling power
// - house-keeping bursts run own timer, no full wake in doze or standby
// - separate peripheral timer reports peripheral idle period
// - throttle output modulated in every state, including full power
// - plane enable outputs switch board power planes under software control
// - suspend waits for the core to drain work before halting
// - clocks stay stopped during suspend; state retained
// - leaving suspend the core resumes where it stopped
module pmu_power_manager
  import pmu_pkg::*;
#(
  parameter int TW     = PMU_TW,
  parameter int PLANES = PMU_PLANES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire pmu_activity_t     activity,
  input  wire pmu_reload_t       reload,
  input  wire logic [3:0]        throttle_duty,
  input  wire logic [PLANES-1:0] plane_enable_sw,
  input  wire logic              state_write,
  input  wire pmu_state_t        state_value,
  input  wire logic              irq_enable_idle,
  input  wire logic              irq_enable_wake,
  input  wire logic              irq_ack,
  input  wire logic              core_idle,
  output logic                   sys_mgmt_interrupt,
  output pmu_cause_t             irq_cause,
  output pmu_state_t             power_state,
  output logic                   suspend_throttle_out,
  output logic                   clock_stop,
  output logic                   core_resume,
  output logic [PLANES-1:0]      plane_enable
);

  // ------------------------------------------------------------
  // timers
  // ------------------------------------------------------------
  function automatic logic [TW-1:0] tick(input logic [TW-1:0] cnt);
    tick = (cnt == '0) ? cnt : cnt - 1'b1;
  endfunction : tick

  function automatic logic at_one(input logic [TW-1:0] cnt);
    at_one = (cnt == TW'(1));
  endfunction : at_one

  logic [TW-1:0] doze_reg, stby_reg, suspend_throttle_out_reg, hk_reg, per_reg;
  logic [TW-1:0] doze_next, stby_next, suspend_throttle_out_next, hk_next, per_next;
  logic          hk_busy;
  logic          sys_act;
  logic          wake_evt;

  assign hk_busy  = (hk_reg != '0);
  // house-keeping in doze or standby holds the timers but is not a wake
  assign sys_act  = activity.system;
  assign wake_evt = activity.system && (power_state != PMU_ON);

  // activity reloads, house-keeping holds the system timers, otherwise count down
  assign doze_next = sys_act ? reload.doze : (hk_busy ? doze_reg : tick(doze_reg));
  assign stby_next = sys_act ? reload.standby : (hk_busy ? stby_reg : tick(stby_reg));
  assign suspend_throttle_out_next = sys_act ? reload.suspend : (hk_busy ? suspend_throttle_out_reg : tick(suspend_throttle_out_reg));
  assign hk_next   = activity.housekeep ? reload.housekeep : tick(hk_reg);
  assign per_next  = activity.periph ? reload.periph : tick(per_reg);

  always_ff @(posedge clk) begin
    if (rst) begin
      doze_reg <= PMU_DOZE_RST;
      stby_reg <= PMU_STBY_RST;
      suspend_throttle_out_reg <= PMU_SUSPEND_THROTTLE_OUT_RST;
      hk_reg   <= '0;
      per_reg  <= PMU_PERIPH_RST;
    end else if (ce) begin
      doze_reg <= doze_next;
      stby_reg <= stby_next;
      suspend_throttle_out_reg <= suspend_throttle_out_next;
      hk_reg   <= hk_next;
      per_reg  <= per_next;
    end
  end

  // expiry pulses on the count reaching zero from one
  logic doze_exp, stby_exp, suspend_throttle_out_exp, per_exp;
  assign doze_exp = ce && !sys_act && !hk_busy && at_one(doze_reg);
  assign stby_exp = ce && !sys_act && !hk_busy && at_one(stby_reg);
  assign suspend_throttle_out_exp = ce && !sys_act && !hk_busy && at_one(suspend_throttle_out_reg);
  assign per_exp  = ce && !activity.periph && at_one(per_reg);

  // ------------------------------------------------------------
  // interrupt causes: set wins over acknowledge
  // ------------------------------------------------------------
  pmu_cause_t set_c, cause_next;
  assign set_c.doze    = doze_exp && irq_enable_idle;
  assign set_c.standby = stby_exp && irq_enable_idle;
  assign set_c.suspend = suspend_throttle_out_exp && irq_enable_idle;
  assign set_c.periph  = per_exp && irq_enable_idle;
  assign set_c.wake    = ce && wake_evt && irq_enable_wake;
  // one acknowledge clears every cause, so software reads irq_cause first
  assign cause_next    = (irq_ack ? '0 : irq_cause) | set_c;

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_cause          <= '0;
      sys_mgmt_interrupt <= 1'b0;
    end else if (ce) begin
      irq_cause          <= cause_next;
      sys_mgmt_interrupt <= |cause_next;
    end
  end

  // ------------------------------------------------------------
  // power state, driven by management software
  // ------------------------------------------------------------
  pmu_sh_t sh_reg, sh_next;

  always_ff @(posedge clk) begin
    if (rst) begin
      power_state <= PMU_ON;
    end else if (ce && state_write) begin
      power_state <= state_value;
    end
  end

  // ------------------------------------------------------------
  // suspend handshake with the core
  // ------------------------------------------------------------
  always_comb begin
    sh_next = sh_reg;
    case (sh_reg)
      PMU_SH_RUN:   if (power_state == PMU_SUSPEND) sh_next = PMU_SH_DRAIN;
      PMU_SH_DRAIN: begin
        // a suspend cancelled before the core drained must not stop clocks later
        if (power_state != PMU_SUSPEND) sh_next = PMU_SH_RUN;
        else if (core_idle) sh_next = PMU_SH_HALT;
      end
      PMU_SH_HALT:  if (power_state != PMU_SUSPEND) sh_next = PMU_SH_WAKE;
      PMU_SH_WAKE:  sh_next = PMU_SH_RUN;
      default:      sh_next = PMU_SH_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_reg      <= PMU_SH_RUN;
      clock_stop  <= 1'b0;
      core_resume <= 1'b0;
    end else if (ce) begin
      sh_reg      <= sh_next;
      clock_stop  <= (sh_next == PMU_SH_HALT);
      core_resume <= (sh_next == PMU_SH_WAKE);
    end
  end

  // ------------------------------------------------------------
  // throttle modulation and power planes
  // ------------------------------------------------------------
  logic [3:0] phase_reg;
  logic       thr_next;
  // duty counts active-high run slots of 16; 4'hF means never throttled
  // the phase runs free, so a new duty may take effect in mid-period
  assign thr_next = (throttle_duty == PMU_THR_RST) || (phase_reg < throttle_duty);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg            <= 4'h0;
      suspend_throttle_out <= 1'b1;
      plane_enable         <= PLANES'(PMU_PLANES_RST);
    end else if (ce) begin
      phase_reg            <= phase_reg + 4'h1;
      suspend_throttle_out <= thr_next;
      plane_enable         <= plane_enable_sw;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_irq_doze: assert property (@(posedge clk) disable iff (rst)
    doze_exp && irq_enable_idle |=> sys_mgmt_interrupt && irq_cause.doze)
    else $error("doze expiry did not raise interrupt");

  a_irq_wake: assert property (@(posedge clk) disable iff (rst)
    ce && activity.system && power_state != PMU_ON && irq_enable_wake |=> irq_cause.wake)
    else $error("wake activity lost");

  a_timer_reload: assert property (@(posedge clk) disable iff (rst)
    ce && activity.system |=> doze_reg == $past(reload.doze))
    else $error("doze timer did not reload");

  a_hk_hold: assert property (@(posedge clk) disable iff (rst)
    ce && hk_busy && !sys_act |=> doze_reg == $past(doze_reg))
    else $error("housekeeping did not hold timer");

  a_per_reload: assert property (@(posedge clk) disable iff (rst)
    ce && activity.periph |=> per_reg == $past(reload.periph))
    else $error("peripheral timer did not reload");

  a_drain_first: assert property (@(posedge clk) disable iff (rst)
    sh_reg == PMU_SH_DRAIN && !core_idle |=> !clock_stop)
    else $error("clock stopped before core drained");

  a_stop_hold: assert property (@(posedge clk) disable iff (rst)
    ce && clock_stop && power_state == PMU_SUSPEND |=> clock_stop)
    else $error("clock restarted during suspend");

  a_resume_pulse: assert property (@(posedge clk) disable iff (rst)
    ce && core_resume |=> !core_resume && !clock_stop)
    else $error("resume pulse malformed");

  a_throttle_full: assert property (@(posedge clk) disable iff (rst)
    ce && throttle_duty == 4'h0 ##1 ce |-> !suspend_throttle_out)
    else $error("throttle not applied");

  a_plane_follow: assert property (@(posedge clk) disable iff (rst)
    ce |=> plane_enable == $past(plane_enable_sw))
    else $error("planes did not follow control");

  a_state_write: assert property (@(posedge clk) disable iff (rst)
    ce && state_write |=> power_state == $past(state_value))
    else $error("state write lost");

  a_irq_standby: assert property (@(posedge clk) disable iff (rst)
    stby_exp && irq_enable_idle |=> sys_mgmt_interrupt && irq_cause.standby)
    else $error("standby expiry did not raise interrupt");

  a_irq_suspend: assert property (@(posedge clk) disable iff (rst)
    suspend_throttle_out_exp && irq_enable_idle |=> sys_mgmt_interrupt && irq_cause.suspend)
    else $error("suspend expiry did not raise interrupt");

  a_irq_periph: assert property (@(posedge clk) disable iff (rst)
    per_exp && irq_enable_idle |=> sys_mgmt_interrupt && irq_cause.periph)
    else $error("peripheral expiry did not raise interrupt");

  a_idle_gated: assert property (@(posedge clk) disable iff (rst)
    ce && irq_ack && !irq_enable_idle |=> irq_cause[4:1] == 4'h0)
    else $error("idle cause set while disabled");

  a_ack_clear: assert property (@(posedge clk) disable iff (rst)
    ce && irq_ack && !irq_enable_idle && !irq_enable_wake |=> !sys_mgmt_interrupt)
    else $error("acknowledge did not clear interrupt");

  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    sys_mgmt_interrupt == (|irq_cause))
    else $error("interrupt does not match causes");

  a_wake_only_down: assert property (@(posedge clk) disable iff (rst)
    ce && power_state == PMU_ON && !irq_cause.wake |=> !irq_cause.wake)
    else $error("wake cause raised at full power");

  a_hk_no_wake: assert property (@(posedge clk) disable iff (rst)
    ce && activity.housekeep && !activity.system && !irq_cause.wake |=> !irq_cause.wake)
    else $error("housekeeping forced a wake");

  a_tmr_stick: assert property (@(posedge clk) disable iff (rst)
    ce && !sys_act && doze_reg == '0 |=> doze_reg == '0)
    else $error("expired timer restarted without activity");

  a_doze_count: assert property (@(posedge clk) disable iff (rst)
    ce && !sys_act && !hk_busy && doze_reg != '0 |=> doze_reg == $past(doze_reg) - 1'b1)
    else $error("doze timer did not count down");

  a_stby_reload: assert property (@(posedge clk) disable iff (rst)
    ce && activity.system |=> stby_reg == $past(reload.standby))
    else $error("standby timer did not reload");

  a_suspend_throttle_out_reload: assert property (@(posedge clk) disable iff (rst)
    ce && activity.system |=> suspend_throttle_out_reg == $past(reload.suspend))
    else $error("suspend timer did not reload");

  a_hk_reload: assert property (@(posedge clk) disable iff (rst)
    ce && activity.housekeep |=> hk_reg == $past(reload.housekeep))
    else $error("housekeeping timer did not reload");

  a_per_count: assert property (@(posedge clk) disable iff (rst)
    ce && !activity.periph && per_reg != '0 |=> per_reg == $past(per_reg) - 1'b1)
    else $error("peripheral timer did not count down");

  a_throttle_free: assert property (@(posedge clk) disable iff (rst)
    ce && throttle_duty == PMU_THR_RST |=> suspend_throttle_out)
    else $error("throttle applied at full duty");

  a_halt_entry: assert property (@(posedge clk) disable iff (rst)
    ce && sh_reg == PMU_SH_DRAIN && core_idle && power_state == PMU_SUSPEND |=> clock_stop)
    else $error("drained core not halted");

  a_drain_exit: assert property (@(posedge clk) disable iff (rst)
    ce && sh_reg == PMU_SH_DRAIN && power_state != PMU_SUSPEND
    |=> sh_reg == PMU_SH_RUN && !clock_stop)
    else $error("cancelled suspend still draining");

  a_resume_after: assert property (@(posedge clk) disable iff (rst)
    ce && clock_stop && power_state != PMU_SUSPEND |=> core_resume && !clock_stop)
    else $error("core not resumed after suspend");

  a_no_stop_on: assert property (@(posedge clk) disable iff (rst)
    ce && power_state == PMU_ON && sh_reg == PMU_SH_RUN |=> !clock_stop)
    else $error("clock stopped outside suspend");

endmodule : pmu_power_manager

// ==== testbench/pmu_core_model.sv ====
// core model: drains its pending work before reporting idle in suspend
`timescale 1ns/1ns
module pmu_core_model
  import pmu_pkg::*;
#(
  parameter int DRAIN = 5
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire pmu_state_t power_state,
  input  wire logic       clock_stop,
  output logic            core_idle
);
  int work_reg;
  // ------------------------------------------------------------
  // drain and halt
  // ------------------------------------------------------------
  // a fresh suspend always finds work in flight, so a block that
  // stops clocks early is caught
  always_ff @(posedge clk) begin
    if (rst || power_state != PMU_SUSPEND) begin
      work_reg <= DRAIN;
    end else if (work_reg != 0) begin
      work_reg <= work_reg - 1;
    end
  end
  assign core_idle = (power_state == PMU_SUSPEND) && (work_reg == 0 || clock_stop);
endmodule : pmu_core_model

// ==== testbench/power_management_unit_bench.sv ====
// self-checking bench for the power manager
`timescale 1ns/1ns
module power_management_unit_bench;
  import pmu_pkg::*;
  logic          clk, rst, ce, state_write, irq_enable_idle, irq_enable_wake, irq_ack;
  logic          core_idle, sys_mgmt_interrupt, suspend_throttle_out, clock_stop, core_resume;
  logic [3:0]    throttle_duty, plane_enable_sw, plane_enable;
  pmu_activity_t act;
  pmu_reload_t   rl;
  pmu_state_t    state_value, power_state;
  pmu_cause_t    irq_cause;
  int            n_fail, n_checks;

  pmu_power_manager dut (.clk(clk), .rst(rst), .ce(ce), .activity(act), .reload(rl),
    .throttle_duty(throttle_duty), .plane_enable_sw(plane_enable_sw),
    .state_write(state_write), .state_value(state_value), .irq_enable_idle(irq_enable_idle),
    .irq_enable_wake(irq_enable_wake), .irq_ack(irq_ack), .core_idle(core_idle),
    .sys_mgmt_interrupt(sys_mgmt_interrupt), .irq_cause(irq_cause), .power_state(power_state),
    .suspend_throttle_out(suspend_throttle_out), .clock_stop(clock_stop),
    .core_resume(core_resume), .plane_enable(plane_enable));
  pmu_core_model core (.clk(clk), .rst(rst), .power_state(power_state),
    .clock_stop(clock_stop), .core_idle(core_idle));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic pulse(input pmu_activity_t a);
    act = a;
    tick(1);
    act = '0;
  endtask : pulse
  task automatic ack;
    irq_ack = 1'b1;
    tick(1);
    irq_ack = 1'b0;
    tick(1);
    chk(sys_mgmt_interrupt, 16'h0000);
  endtask : ack
  task automatic wr(input pmu_state_t s);
    state_value = s;
    state_write = 1'b1;
    tick(1);
    state_write = 1'b0;
    tick(1);
  endtask : wr

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // k: 0 doze, 1 standby, 2 suspend, 3 peripheral
  task automatic idle_tmr(input int k, input logic en);
    rl = '{default: 16'hFFFF};
    rl.housekeep = 16'h0000;
    case (k)
      0: rl.doze = 16'h0003;
      1: rl.standby = 16'h0003;
      2: rl.suspend = 16'h0003;
      default: rl.periph = 16'h0003;
    endcase
    irq_enable_idle = en;
    pulse('{system: 1'b1, housekeep: 1'b0, periph: 1'b1});
    tick(2);
    chk(irq_cause, 16'h0000);
    tick(5);
    chk(irq_cause, en ? (16'h0010 >> k) : 16'h0000);
    ack();
  endtask : idle_tmr
  task automatic housekeep_burst;
    rl = '{default: 16'hFFFF};
    rl.doze = 16'h0003;
    rl.housekeep = 16'h000A;
    pulse('{system: 1'b1, housekeep: 1'b1, periph: 1'b1});
    tick(7);
    chk(irq_cause, 16'h0000);
    tick(12);
    chk(irq_cause, 16'h0010);
    ack();
  endtask : housekeep_burst
  task automatic wake_up;
    rl = '{default: 16'hFFFF};
    rl.housekeep = 16'h0004;
    irq_enable_wake = 1'b1;
    pulse('{system: 1'b1, housekeep: 1'b0, periph: 1'b0});
    tick(3);
    chk(irq_cause, 16'h0000);
    wr(PMU_STANDBY);
    chk(power_state, PMU_STANDBY);
    pulse('{system: 1'b0, housekeep: 1'b1, periph: 1'b0});
    tick(2);
    chk(irq_cause, 16'h0000);
    pulse('{system: 1'b1, housekeep: 1'b0, periph: 1'b0});
    tick(2);
    chk(irq_cause, 16'h0001);
    ack();
    wr(PMU_ON);
  endtask : wake_up
  task automatic suspend_cycle;
    wr(PMU_SUSPEND);
    chk(clock_stop, 16'h0000);
    for (int i = 0; i < 20 && !clock_stop; i++) tick(1);
    chk({core_idle, clock_stop}, 16'h0003);
    tick(10);
    chk({power_state, clock_stop}, 16'h0007);
    state_value = PMU_ON;
    state_write = 1'b1;
    tick(1);
    state_write = 1'b0;
    tick(1);
    chk({clock_stop, core_resume}, 16'h0001);
    tick(1);
    chk(core_resume, 16'h0000);
  endtask : suspend_cycle
  task automatic throttle(input pmu_state_t s, input logic [3:0] d, input int exp);
    int hi;
    hi = 0;
    wr(s);
    throttle_duty = d;
    tick(2);
    for (int i = 0; i < 32; i++) begin
      hi += suspend_throttle_out;
      tick(1);
    end
    chk(hi[15:0], exp[15:0]);
  endtask : throttle
  task automatic suspend_abort;
    wr(PMU_SUSPEND);
    wr(PMU_ON);
    chk(clock_stop, 16'h0000);
    tick(10);
    chk({clock_stop, core_resume}, 16'h0000);
  endtask : suspend_abort
  task automatic plane_follow;
    plane_enable_sw = 4'h5;
    tick(1);
    chk(plane_enable, 16'h0005);
    plane_enable_sw = 4'hA;
    tick(1);
    chk(plane_enable, 16'h000A);
  endtask : plane_follow
  task automatic reset_values;
    chk({sys_mgmt_interrupt, irq_cause, power_state, suspend_throttle_out, clock_stop,
         core_resume, plane_enable}, 16'h004F);
  endtask : reset_values

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    {ce, rst} = 2'b11;
    {state_write, irq_enable_idle, irq_enable_wake, irq_ack} = '0;
    act = '0;
    rl = '{default: 16'hFFFF};
    state_value = PMU_ON;
    throttle_duty = 4'hF;
    plane_enable_sw = 4'hF;
    n_fail = 0;
    n_checks = 0;
    tick(6);
    rst = 1'b0;
    reset_values();
    for (int k = 0; k < 4; k++) idle_tmr(k, 1'b1);
    idle_tmr(0, 1'b0);
    irq_enable_idle = 1'b1;
    housekeep_burst();
    wake_up();
    suspend_abort();
    suspend_cycle();
    throttle(PMU_ON, 4'h4, 8);
    throttle(PMU_DOZE, 4'h4, 8);
    throttle(PMU_STANDBY, 4'h0, 0);
    throttle(PMU_ON, 4'hF, 32);
    plane_follow();
    conclude();
  end
endmodule : power_management_unit_bench
